// *** cssw_top.sv ***
// Standby rate control, power-down and wake-up discriminator of the two-channel front end.
`include "cssw_map.svh"

module cssw_top #(
    // Cycles per full-rate conversion; shorten for simulation.
    parameter int CONV_BASE_CYCLES =
        (`CSSW_CLK_HZ + `CSSW_CONV_RATE_HZ - 1) / `CSSW_CONV_RATE_HZ
) (
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 reset_n,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [7:0]           reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [7:0]           reg_rdata,
    // Converter results
    input  wire cssw_pkg::cssw_conv_s ch1_conv,
    input  wire cssw_pkg::cssw_conv_s ch2_conv,
    // Front-end control
    output logic                      ch1_conv_start,
    output logic                      ch2_conv_start,
    output logic                      excitation_enable,
    output logic                      afe_reset,
    output logic                      standby_active,
    // Processor interrupts
    output logic                      wake_irq,
    output logic                      ready_irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [2:0]               pwr_reg;
    cssw_pkg::cssw_rate_t     div_reg;
    cssw_pkg::cssw_rate_t     sub_reg;
    logic [2:0]               wcfg_reg      [2];
    logic [7:0]               abs_thr_reg   [2];
    logic [7:0]               slope_thr_reg [2];
    logic [1:0]               ready_flag_reg;
    logic [1:0]               wake_flag_reg;
    logic [7:0]               rdata_reg;
    logic [7:0]               rd_mux;
    logic [16:0]              base_cnt_reg;
    cssw_pkg::cssw_rate_t     div_cnt_reg;
    cssw_pkg::cssw_rate_t     sub_cnt_reg;
    logic                     start1_reg;
    logic                     start2_reg;
    cssw_pkg::cssw_rate_t     d_eff;
    cssw_pkg::cssw_rate_t     s_eff;
    logic                     base_tick;
    logic                     div_tick;
    logic                     sub_tick;
    logic                     afe_hold;
    logic                     standby;
    logic                     any_wake;
    logic [1:0]               chan_on;
    cssw_pkg::cssw_conv_s     conv_arr      [2];
    cssw_pkg::cssw_chan_s     chan_arr      [2];
    cssw_pkg::cssw_wake_cfg_s cfg_arr       [2];

    // ------------------------------------------------------------------
    // Power and standby control
    // ------------------------------------------------------------------

    // Both channels down parks the whole front end and clears its results, but not the control registers.
    assign afe_hold = pwr_reg[`CSSW_PWR_PD1] & pwr_reg[`CSSW_PWR_PD2];
    assign standby  = pwr_reg[`CSSW_PWR_SB];
    assign chan_on  = {~pwr_reg[`CSSW_PWR_PD2], ~pwr_reg[`CSSW_PWR_PD1]};
    assign any_wake = chan_arr[0].wake | chan_arr[1].wake;

    // Power register; a wake clears the standby bit and beats a software write.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n) begin
            pwr_reg <= `CSSW_PWR_RESET;
        end else begin
            if (reg_wr && reg_addr == `CSSW_OFS_PWR) begin
                pwr_reg <= reg_wdata[2:0];
            end
            if (any_wake) begin
                pwr_reg[`CSSW_PWR_SB] <= 1'b0;
            end
        end
    end

    // Rate fields, reset to one so both channels start at full rate.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n) begin
            div_reg <= `CSSW_RATE_RESET;
            sub_reg <= `CSSW_RATE_RESET;
        end else if (reg_wr) begin
            if (reg_addr == `CSSW_OFS_DIV) begin
                div_reg <= reg_wdata[4:0];
            end
            if (reg_addr == `CSSW_OFS_SUB) begin
                sub_reg <= reg_wdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Conversion rate generation
    // ------------------------------------------------------------------

    // A zero field is taken as one, and outside standby no division applies.
    always_comb
    begin
        d_eff = `CSSW_RATE_RESET;
        s_eff = `CSSW_RATE_RESET;
        if (standby && div_reg != 5'h00) begin
            d_eff = div_reg;
        end
        if (standby && sub_reg != 5'h00) begin
            s_eff = sub_reg;
        end
    end

    assign base_tick = base_cnt_reg == 17'(CONV_BASE_CYCLES - 1);
    // Compare with >= so that a divider lowered mid-count never stalls the chain.
    assign div_tick  = base_tick & (div_cnt_reg >= (d_eff - 5'h01));
    assign sub_tick  = div_tick & (sub_cnt_reg >= (s_eff - 5'h01));

    // Full-rate base counter; its period keeps each channel at or below top rate.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n) begin
            base_cnt_reg <= 17'h00000;
        end else if (afe_hold || base_tick) begin
            base_cnt_reg <= 17'h00000;
        end else begin
            base_cnt_reg <= base_cnt_reg + 17'h00001;
        end
    end

    // Shared divider stage, feeding channel 1 directly.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n) begin
            div_cnt_reg <= 5'h00;
        end else if (afe_hold || div_tick) begin
            div_cnt_reg <= 5'h00;
        end else if (base_tick) begin
            div_cnt_reg <= div_cnt_reg + 5'h01;
        end
    end

    // Channel 2 subdivider counts the shared divider's output, giving D times S.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n) begin
            sub_cnt_reg <= 5'h00;
        end else if (afe_hold || sub_tick) begin
            sub_cnt_reg <= 5'h00;
        end else if (div_tick) begin
            sub_cnt_reg <= sub_cnt_reg + 5'h01;
        end
    end

    // Start pulses, suppressed for a powered-down channel.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n) begin
            start1_reg <= 1'b0;
            start2_reg <= 1'b0;
        end else begin
            start1_reg <= div_tick & chan_on[0] & ~afe_hold;
            start2_reg <= sub_tick & chan_on[1] & ~afe_hold;
        end
    end

    // ------------------------------------------------------------------
    // Per-channel wake settings, discriminator and flags
    // ------------------------------------------------------------------
    assign conv_arr[0] = ch1_conv;
    assign conv_arr[1] = ch2_conv;

    generate
        for (genvar ch = 0; ch < 2; ch++) begin : g_chan
            localparam logic [7:0] OFS_CFG = 8'(`CSSW_OFS_WCFG1 + ch);
            localparam logic [7:0] OFS_ABS = 8'(`CSSW_OFS_ABS1 + ch);
            localparam logic [7:0] OFS_SLP = 8'(`CSSW_OFS_SLP1 + ch);

            // Each channel keeps its own thresholds, combine and enables.
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n) begin
                    wcfg_reg[ch]      <= `CSSW_CFG_RESET;
                    abs_thr_reg[ch]   <= `CSSW_THR_RESET;
                    slope_thr_reg[ch] <= `CSSW_THR_RESET;
                end else if (reg_wr) begin
                    if (reg_addr == OFS_CFG) begin
                        wcfg_reg[ch] <= reg_wdata[2:0];
                    end
                    if (reg_addr == OFS_ABS) begin
                        abs_thr_reg[ch] <= reg_wdata;
                    end
                    if (reg_addr == OFS_SLP) begin
                        slope_thr_reg[ch] <= reg_wdata;
                    end
                end
            end

            assign cfg_arr[ch] = '{combine_and: wcfg_reg[ch][`CSSW_WCFG_COMB],
                                   abs_en:      wcfg_reg[ch][`CSSW_WCFG_AE],
                                   slope_en:    wcfg_reg[ch][`CSSW_WCFG_RE],
                                   abs_thr:     abs_thr_reg[ch],
                                   slope_thr:   slope_thr_reg[ch]};

            cssw_chan_eval u_eval (
                .sys_clk  (sys_clk),
                .reset_n  (reset_n),
                .afe_hold (afe_hold),
                .chan_on  (chan_on[ch]),
                .standby  (standby),
                .cfg      (cfg_arr[ch]),
                .conv     (conv_arr[ch]),
                .chan     (chan_arr[ch])
            );

            // Sticky flags; a new event in the clearing cycle keeps the flag set.
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n) begin
                    ready_flag_reg[ch] <= 1'b0;
                    wake_flag_reg[ch]  <= 1'b0;
                end else begin
                    ready_flag_reg[ch] <= chan_arr[ch].stored | (ready_flag_reg[ch]
                        & ~(reg_wr && reg_addr == `CSSW_OFS_STAT
                            && reg_wdata[`CSSW_STAT_RDY_LSB + ch]));
                    wake_flag_reg[ch]  <= chan_arr[ch].wake | (wake_flag_reg[ch]
                        & ~(reg_wr && reg_addr == `CSSW_OFS_STAT
                            && reg_wdata[`CSSW_STAT_WAKE_LSB + ch]));
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------------

    // Unmapped and reserved bits read as zero.
    always_comb
    begin
        rd_mux = 8'h00;
        case (reg_addr)
            `CSSW_OFS_PWR:   rd_mux = {5'h00, pwr_reg};
            `CSSW_OFS_DIV:   rd_mux = {3'h0, div_reg};
            `CSSW_OFS_SUB:   rd_mux = {3'h0, sub_reg};
            `CSSW_OFS_WCFG1: rd_mux = {5'h00, wcfg_reg[0]};
            `CSSW_OFS_WCFG2: rd_mux = {5'h00, wcfg_reg[1]};
            `CSSW_OFS_ABS1:  rd_mux = abs_thr_reg[0];
            `CSSW_OFS_ABS2:  rd_mux = abs_thr_reg[1];
            `CSSW_OFS_SLP1:  rd_mux = slope_thr_reg[0];
            `CSSW_OFS_SLP2:  rd_mux = slope_thr_reg[1];
            `CSSW_OFS_RES1L: rd_mux = chan_arr[0].result[7:0];
            `CSSW_OFS_RES1H: rd_mux = {chan_arr[0].overrange, 3'h0, chan_arr[0].result[11:8]};
            `CSSW_OFS_RES2L: rd_mux = chan_arr[1].result[7:0];
            `CSSW_OFS_RES2H: rd_mux = {chan_arr[1].overrange, 3'h0, chan_arr[1].result[11:8]};
            `CSSW_OFS_STAT:  rd_mux = {4'h0, wake_flag_reg, ready_flag_reg};
            default:         rd_mux = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe; zero otherwise.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            rdata_reg <= rd_mux;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata         = rdata_reg;
    assign ch1_conv_start    = start1_reg;
    assign ch2_conv_start    = start2_reg;
    assign excitation_enable = ~afe_hold;
    assign afe_reset         = afe_hold;
    assign standby_active    = standby;
    // The wake line is a level that lasts as long as a wake flag is set.
    assign wake_irq          = |wake_flag_reg;
    assign ready_irq         = |ready_flag_reg;

endmodule : cssw_top

// *** cssw_map.svh ***
// Register offsets, field positions, reset values and timing constants of the standby wake block.
// Contract
// - Channel 1 rate is base divided by D; the code applies D only in standby.
// - One divider field serves both channels.
// - Channel 2 rate divided further by S; the code applies S only in standby.
// - D and S reset to one.
// - Each channel has its own power-down bit.
// - Excitation stops only when both channels down.
// - Both down holds front end in reset.
// - Wake clears standby and raises interrupt together.
// - Absolute threshold compares result bits eleven to four.
// - Slope threshold aligned to result bits eleven to four.
// - Combine bit selects AND or OR.
// - Enable bits gate absolute and slope detection.
// - Wake settings are held per channel.
// - Result split into low and high bytes.
// - Overrange flag follows the latest conversion.
// - Stored result sets channel ready flag.
// - New result overwrites the old one.
// - Channel wake sets its own wake flag.
// - One shared bit enters and leaves standby.
`ifndef CSSW_MAP_SVH
`define CSSW_MAP_SVH
`define CSSW_CLK_HZ          200000000
`define CSSW_CONV_RATE_HZ    1660
`define CSSW_OFS_PWR         8'h00
`define CSSW_OFS_DIV         8'h01
`define CSSW_OFS_SUB         8'h02
`define CSSW_OFS_WCFG1       8'h03
`define CSSW_OFS_WCFG2       8'h04
`define CSSW_OFS_ABS1        8'h05
`define CSSW_OFS_ABS2        8'h06
`define CSSW_OFS_SLP1        8'h07
`define CSSW_OFS_SLP2        8'h08
`define CSSW_OFS_RES1L       8'h09
`define CSSW_OFS_RES1H       8'h0a
`define CSSW_OFS_RES2L       8'h0b
`define CSSW_OFS_RES2H       8'h0c
`define CSSW_OFS_STAT        8'h0d
`define CSSW_PWR_SB          0
`define CSSW_PWR_PD1         1
`define CSSW_PWR_PD2         2
`define CSSW_WCFG_COMB       0
`define CSSW_WCFG_AE         1
`define CSSW_WCFG_RE         2
`define CSSW_STAT_RDY_LSB    0
`define CSSW_STAT_WAKE_LSB   2
`define CSSW_RATE_RESET      5'h01
`define CSSW_PWR_RESET       3'h0
`define CSSW_CFG_RESET       3'h0
`define CSSW_THR_RESET       8'h00
`endif

// *** cssw_pkg.sv ***
// Shared types of the standby wake block.
package cssw_pkg;

    // One conversion handed over by the converter.
    typedef struct packed {
        logic        done;
        logic        overrange;
        logic [11:0] data;
    } cssw_conv_s;

    // Wake settings of one channel.
    typedef struct packed {
        logic       combine_and;
        logic       abs_en;
        logic       slope_en;
        logic [7:0] abs_thr;
        logic [7:0] slope_thr;
    } cssw_wake_cfg_s;

    // State that one channel reports upward.
    typedef struct packed {
        logic        stored;
        logic        wake;
        logic        overrange;
        logic [11:0] result;
    } cssw_chan_s;

    // Five-bit rate divider field.
    typedef logic [4:0] cssw_rate_t;

endpackage : cssw_pkg

// *** cssw_chan_eval.sv ***
// Result store and wake discriminator of one channel.
module cssw_chan_eval (
    // Clock and reset
    input  wire logic                     sys_clk,
    input  wire logic                     reset_n,
    // Front-end control
    input  wire logic                     afe_hold,
    input  wire logic                     chan_on,
    input  wire logic                     standby,
    input  wire cssw_pkg::cssw_wake_cfg_s cfg,
    // Converter side
    input  wire cssw_pkg::cssw_conv_s     conv,
    // Channel report
    output cssw_pkg::cssw_chan_s          chan
);
    logic [11:0] result_reg;
    logic        ovr_reg;
    logic        prev_valid_reg;
    logic        stored_reg;
    logic        wake_reg;
    logic        take;
    logic [11:0] delta;
    logic        abs_hit;
    logic        slope_hit;
    logic        wake_cond;

    // A result is accepted only from a live, powered channel.
    assign take = conv.done & chan_on & ~afe_hold;

    // Slope is the distance between the new result and the stored one.
    always_comb
    begin
        delta     = (conv.data >= result_reg) ? (conv.data - result_reg)
                                              : (result_reg - conv.data);
        abs_hit   = conv.data[11:4] > cfg.abs_thr;
        slope_hit = prev_valid_reg & (delta[11:4] > cfg.slope_thr);
        if (cfg.combine_and)
            wake_cond = (cfg.abs_en | cfg.slope_en) & (~cfg.abs_en | abs_hit)
                      & (~cfg.slope_en | slope_hit);
        else
            wake_cond = (cfg.abs_en & abs_hit) | (cfg.slope_en & slope_hit);
    end

    // The store is overwritten on every conversion, read or not.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n) begin
            result_reg     <= 12'h000;
            ovr_reg        <= 1'b0;
            prev_valid_reg <= 1'b0;
        end else if (afe_hold) begin
            result_reg     <= 12'h000;
            ovr_reg        <= 1'b0;
            prev_valid_reg <= 1'b0;
        end else if (take) begin
            result_reg     <= conv.data;
            ovr_reg        <= conv.overrange;
            prev_valid_reg <= 1'b1;
        end
    end

    // Event pulses, one cycle each, in step with the store update.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n) begin
            stored_reg <= 1'b0;
            wake_reg   <= 1'b0;
        end else begin
            stored_reg <= take;
            wake_reg   <= take & standby & wake_cond;
        end
    end

    assign chan = '{stored: stored_reg, wake: wake_reg, overrange: ovr_reg, result: result_reg};

endmodule : cssw_chan_eval

// *** cssw_conv_model.sv ***
// Converter stand-in that answers each start request of one channel.
module cssw_conv_model (
    // Clock and reset
    input  wire logic            sys_clk,
    input  wire logic            reset_n,
    // Request and the value to return, overrange on top
    input  wire logic            start,
    input  wire logic [12:0]     value,
    // Result towards the block
    output cssw_pkg::cssw_conv_s conv
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [2:0] busy_reg;

    // --------------------------------------------------------------
    // Conversion pipe
    // --------------------------------------------------------------
    // A result follows its start by four cycles; data toggle between results.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            busy_reg <= 3'h0;
            conv     <= '0;
        end
        else
        begin
            busy_reg       <= {busy_reg[1:0], start};
            conv.done      <= busy_reg[2];
            conv.overrange <= busy_reg[2] ? value[12] : ~conv.overrange;
            conv.data      <= busy_reg[2] ? value[11:0] : ~conv.data;
        end
    end
endmodule : cssw_conv_model

// *** cssw_top_props.sv ***
// Concurrent checks of the standby wake block.
module cssw_top_props #(
    parameter int CONV_BASE_CYCLES = 20
) (
    // Clock and reset
    input wire logic                 sys_clk,
    input wire logic                 reset_n,
    // Register port
    input wire logic [7:0]           reg_addr,
    input wire logic [7:0]           reg_wdata,
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [7:0]           reg_rdata,
    // Converter and front end
    input wire cssw_pkg::cssw_conv_s ch1_conv,
    input wire cssw_pkg::cssw_conv_s ch2_conv,
    input wire logic                 ch1_conv_start,
    input wire logic                 ch2_conv_start,
    input wire logic                 excitation_enable,
    input wire logic                 afe_reset,
    input wire logic                 standby_active,
    // Interrupts
    input wire logic                 wake_irq,
    input wire logic                 ready_irq
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] pd_reg;
    logic [4:0] div_reg;
    logic [4:0] sub_reg;
    logic       sb_q, sb_q2, ok1, ok2, chg;
    int         gap1, gap2, d_eff, s_eff;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // --------------------------------------------------------------
    // Helper logic
    // --------------------------------------------------------------
    // Mirror of the power-down bits and rate fields.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pd_reg  <= 2'h0;
            div_reg <= 5'h01;
            sub_reg <= 5'h01;
        end
        else if (reg_wr && reg_addr == 8'h00)
            pd_reg <= reg_wdata[2:1];
        else if (reg_wr && reg_addr == 8'h01)
            div_reg <= reg_wdata[4:0];
        else if (reg_wr && reg_addr == 8'h02)
            sub_reg <= reg_wdata[4:0];
    end

    // A mode change spoils a period, so those around it are skipped.
    assign chg   = afe_reset || standby_active != sb_q || sb_q != sb_q2;
    assign d_eff = (div_reg == 5'h00) ? 1 : int'(div_reg);
    assign s_eff = (sub_reg == 5'h00) ? 1 : int'(sub_reg);

    // Cycles since the last start of each channel.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {sb_q, sb_q2, ok1, ok2} <= 4'h0;
            gap1 <= 0;
            gap2 <= 0;
        end
        else
        begin
            sb_q  <= standby_active;
            sb_q2 <= sb_q;
            gap1  <= ch1_conv_start ? 1 : gap1 + 1;
            gap2  <= ch2_conv_start ? 1 : gap2 + 1;
            ok1   <= (chg || pd_reg[0]) ? 1'b0 : (ok1 | ch1_conv_start);
            ok2   <= (chg || pd_reg[1]) ? 1'b0 : (ok2 | ch2_conv_start);
        end
    end

    AST_EXC_FOLLOWS_PD: assert property (excitation_enable == !(&pd_reg))
        else $error("excitation mismatch");
    AST_HOLD_FOLLOWS_PD: assert property (afe_reset == (&pd_reg))
        else $error("hold mismatch");
    AST_HOLD_NO_START: assert property (afe_reset && $past(afe_reset) |-> !ch1_conv_start && !ch2_conv_start)
        else $error("start while held");
    AST_READY_ON_STORE: assert property ((ch1_conv.done && !pd_reg[0] || ch2_conv.done && !pd_reg[1]) && !(&pd_reg) |=> ##1 ready_irq)
        else $error("no ready after store");
    AST_WAKE_LEAVES_SB: assert property ($rose(wake_irq) |-> $fell(standby_active))
        else $error("wake kept standby");
    AST_READY_STICKS: assert property (ready_irq && !(reg_wr && reg_addr == 8'h0d) |=> ready_irq)
        else $error("ready dropped");
    AST_WAKE_STICKS: assert property (wake_irq && !(reg_wr && reg_addr == 8'h0d) |=> wake_irq)
        else $error("wake dropped");
    AST_CH1_PERIOD: assert property (ch1_conv_start && ok1 && !chg |-> gap1 == CONV_BASE_CYCLES * (standby_active ? d_eff : 1))
        else $error("ch1 spacing");
    AST_CH2_PERIOD: assert property (ch2_conv_start && ok2 && !chg |-> gap2 == CONV_BASE_CYCLES * (standby_active ? d_eff * s_eff : 1))
        else $error("ch2 spacing");

    cover property ($rose(wake_irq));
    cover property (standby_active && ch2_conv_start);
    cover property ($rose(afe_reset));
endmodule : cssw_top_props

bind cssw_top cssw_top_props #(.CONV_BASE_CYCLES(CONV_BASE_CYCLES)) props_u (
    .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ch1_conv,
    .ch2_conv, .ch1_conv_start, .ch2_conv_start, .excitation_enable, .afe_reset,
    .standby_active, .wake_irq, .ready_irq
);

// *** cssw_top_test.sv ***
// Self-checking bench of the standby wake block.
module cssw_top_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic                 sys_clk, reset_n, reg_wr, reg_rd;
    logic [7:0]           reg_addr, reg_wdata, reg_rdata, v;
    logic                 c1_start, c2_start, exc_en, afe_rst, sb_on, wake_irq, ready_irq;
    logic [12:0]          val1, val2;
    cssw_pkg::cssw_conv_s conv1, conv2;
    int                   err_total = 0;
    int                   n_checks = 0;

    // Short base period keeps standby waits brief.
    cssw_top #(.CONV_BASE_CYCLES(20)) dut_u (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ch1_conv(conv1),
        .ch2_conv(conv2), .ch1_conv_start(c1_start), .ch2_conv_start(c2_start),
        .excitation_enable(exc_en), .afe_reset(afe_rst), .standby_active(sb_on),
        .wake_irq(wake_irq), .ready_irq(ready_irq));
    cssw_conv_model conv1_u (.sys_clk(sys_clk), .reset_n(reset_n), .start(c1_start),
        .value(val1), .conv(conv1));
    cssw_conv_model conv2_u (.sys_clk(sys_clk), .reset_n(reset_n), .start(c2_start),
        .value(val2), .conv(conv2));

    // --------------------------------------------------------------
    // Bus tasks and comparison
    // --------------------------------------------------------------
    // Each access ends with one idle cycle.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        v = reg_rdata;
    endtask : rd

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        chk($sformatf("reg %h", a), e, v);
    endtask : rc

    task automatic wait_irq(input logic w);
        for (int i = 0; i < 400 && (w ? wake_irq : ready_irq) !== 1'b1; i++)
            @(posedge sys_clk);
        chk("irq", 8'h01, {7'h0, w ? wake_irq : ready_irq});
    endtask : wait_irq

    task automatic results;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Ends a hang after ten thousand cycles.
    initial
    begin
        #50000;
        err_total++;
        $display("BAD watchdog exp done got hang");
        results();
    end

    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    initial
    begin
        {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, val1, val2} = '0;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        // Reset values, then one unmapped address.
        rc(8'h0d, 8'h00);
        for (int a = 0; a < 14; a++)
            rc(a == 13 ? 8'h20 : 8'(a), (a == 1 || a == 2) ? 8'h01 : 8'h00);
        // Result bytes, overrange, ready flags and overwrite.
        val1 <= {1'b1, 12'habc};
        val2 <= {1'b0, 12'h123};
        wr(8'h0d, 8'h03);
        wait_irq(1'b0);
        rc(8'h09, 8'hbc);
        rc(8'h0a, 8'h8a);
        rc(8'h0b, 8'h23);
        rc(8'h0c, 8'h01);
        rc(8'h0d, 8'h03);
        wr(8'h0d, 8'h03);
        rc(8'h0d, 8'h00);
        val1 <= {1'b0, 12'h456};
        wait_irq(1'b0);
        rc(8'h09, 8'h56);
        rc(8'h0a, 8'h04);
        // One channel down: its results are refused, the other converts.
        wr(8'h00, 8'h02);
        val1 <= {1'b0, 12'h777};
        val2 <= {1'b0, 12'h0aa};
        wr(8'h0d, 8'h03);
        chk("exc", 8'h01, {7'h0, exc_en});
        wait_irq(1'b0);
        repeat (2) @(posedge sys_clk);
        rc(8'h0d, 8'h02);
        rc(8'h09, 8'h56);
        rc(8'h0b, 8'haa);
        // Both down clears results and keeps controls and flags.
        wr(8'h00, 8'h06);
        chk("exc", 8'h00, {7'h0, exc_en});
        chk("hold", 8'h01, {7'h0, afe_rst});
        wr(8'h01, 8'h02);
        wr(8'h02, 8'h03);
        rc(8'h0b, 8'h00);
        rc(8'h02, 8'h03);
        rc(8'h0d, 8'h02);
        // Channel 1 absolute only in OR; channel 2 both events in AND.
        wr(8'h03, 8'h02);
        wr(8'h05, 8'h80);
        wr(8'h04, 8'h07);
        wr(8'h06, 8'h10);
        wr(8'h08, 8'h05);
        val1 <= {1'b0, 12'h80f};
        val2 <= {1'b0, 12'h200};
        wr(8'h00, 8'h00);
        wr(8'h0d, 8'h0f);
        wr(8'h00, 8'h01);
        chk("sb", 8'h01, {7'h0, sb_on});
        repeat (500) @(posedge sys_clk);
        chk("wake", 8'h00, {7'h0, wake_irq});
        val2 <= {1'b0, 12'h260};
        wait_irq(1'b1);
        chk("sb", 8'h00, {7'h0, sb_on});
        rd(8'h0d);
        chk("wake bits", 8'h08, v & 8'h0c);
        wr(8'h0d, 8'h0c);
        chk("irq", 8'h00, {7'h0, wake_irq});
        wr(8'h00, 8'h01);
        val1 <= {1'b0, 12'h810};
        wait_irq(1'b1);
        rd(8'h0d);
        chk("wake bits", 8'h04, v & 8'h0c);
        results();
    end
endmodule : cssw_top_test
